// File: rtl/dbsp_pkg.sv
// Package of widths, timing figures and state types for the burst SRAM port logic
package dbsp_pkg;

   // ----------------------------------------------------------------
   // Data organisation
   // ----------------------------------------------------------------
   localparam int WORD_W     = 18;              // One data word on either port
   localparam int LANE_W     = 9;               // One byte lane
   localparam int LANES      = 2;               // Byte lanes per word
   localparam int BURST_LEN  = 2;               // Words per access
   localparam int COMMIT_W   = WORD_W * BURST_LEN; // Bits committed per write
   localparam int ADDR_W     = 8;               // Burst address width of this model
   localparam int MEM_WORDS  = (1 << ADDR_W) * BURST_LEN;

   // ----------------------------------------------------------------
   // Timing figures and derived cycle counts
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_MHZ   = 10;          // Rate of clk
   localparam int LOCK_TIME_US   = 20;          // Loop lock time after a stable clock
   localparam int LOCK_CYCLES    = LOCK_TIME_US * CLK_FREQ_MHZ;
   localparam int LOCK_CNT_W     = $clog2(LOCK_CYCLES + 1);
   localparam int RECAL_CYCLES   = 1024;        // Impedance update period
   localparam int RECAL_CNT_W    = $clog2(RECAL_CYCLES);
   localparam int PLL_RESET_NS   = 30;          // Least clock stop that resets the loop
   localparam int LEGACY_MAX_MHZ = 167;         // Highest rate with the loop turned off

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [WORD_W-1:0] READ_DATA_RST = 18'h00000;
   localparam logic [LANES-1:0]  LANES_OFF     = 2'h3;

   // Loop state as seen by the system side
   typedef enum logic [1:0] {
      PLL_OFF,
      PLL_ACQUIRE,
      PLL_LOCKED
   } dbsp_pll_state_type;

endpackage

// File: rtl/dbsp_sync.sv
// Two flip-flop level synchroniser for signals entering a clock domain
`timescale 1ns/10ps
module dbsp_sync #(
   parameter int WIDTH = 1                      // Bits carried, each independent
) (
   input  wire logic             clk,           // Destination clock
   input  wire logic [WIDTH-1:0] d,             // Asynchronous level in
   output logic      [WIDTH-1:0] q              // Synchronised level out
);

   // ----------------------------------------------------------------
   // Stages
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] meta;

   // First stage feeds only the second one
   always_ff @(posedge clk) begin
      meta <= d;
      q    <= meta;
   end

endmodule

// File: rtl/dbsp_top.sv
// Port logic of a two-word burst SRAM with DDR read and write ports
`timescale 1ns/10ps
module dbsp_top (
   input  wire logic                           clk,                // System clock, 10 MHz
   input  wire logic                           sys_rst,            // Synchronous reset, active high
   input  wire logic                           input_timing_pos,   // Input clock; its fall is the negative rise
   input  wire logic                           output_timing_pos,  // Output clock pin, sampled as strap
   input  wire logic                           output_timing_neg,  // Output clock pin, sampled as strap
   input  wire logic                           pll_bypass_n,       // Low turns the loop off
   input  wire logic                           read_port_sel_n,    // Read port select, active low
   input  wire logic                           write_port_sel_n,   // Write port select, active low
   input  wire logic [dbsp_pkg::ADDR_W-1:0]    address,            // Shared address bus
   input  wire logic [dbsp_pkg::WORD_W-1:0]    write_data,         // Write data word
   input  wire logic [dbsp_pkg::LANES-1:0]     byte_lane_write_n,  // Byte lane write selects, active low
   output logic      [dbsp_pkg::WORD_W-1:0]    read_q_rise,        // Read word launched at clock rise
   output logic                                read_oe_rise,       // Read drive enable for the rise half
   output logic      [dbsp_pkg::WORD_W-1:0]    read_q_fall,        // Read word launched at clock fall
   output logic                                read_oe_fall,       // Read drive enable for the fall half
   output logic                                strobe_pos_rise,    // Positive strobe, rise half
   output logic                                strobe_pos_fall,    // Positive strobe, fall half
   output logic                                strobe_neg_rise,    // Negative strobe, rise half
   output logic                                strobe_neg_fall,    // Negative strobe, fall half
   output logic                                single_clock_mode,  // Strap captured after reset
   output logic                                pll_locked,         // Loop lock status, system domain
   output logic                                impedance_update    // One-cycle recalibration pulse
);
   import dbsp_pkg::*;

   // ----------------------------------------------------------------
   // Decoding shared by the commit and forwarding paths
   // ----------------------------------------------------------------

   // Merge a new word into an old one under active-low lane selects
   function automatic logic [WORD_W-1:0] lane_merge(
      input logic [WORD_W-1:0] old_w,
      input logic [WORD_W-1:0] new_w,
      input logic [LANES-1:0]  lane_n
   );
      logic [WORD_W-1:0] merged;
      merged = old_w;
      for (int i = 0; i < LANES; i++) begin
         if (!lane_n[i]) begin
            merged[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
         end
      end
      return merged;
   endfunction

   // ----------------------------------------------------------------
   // Domain crossings
   // ----------------------------------------------------------------
   logic       link_rst;                        // Reset seen by the link logic
   logic       link_bypass_n;                   // Bypass level in link domain
   logic [1:0] link_strap;                      // Output clock levels in link domain
   logic       sys_bypass_n;                    // Bypass level in system domain

   // The link clock must run while reset is held so the link side resets too
   dbsp_sync #(.WIDTH(4)) u_link_sync (
      .clk (input_timing_pos),
      .d   ({sys_rst, pll_bypass_n, output_timing_pos, output_timing_neg}),
      .q   ({link_rst, link_bypass_n, link_strap})
   );

   // Bypass pin also steers the lock tracker
   dbsp_sync #(.WIDTH(1)) u_sys_sync (
      .clk (clk),
      .d   (pll_bypass_n),
      .q   (sys_bypass_n)
   );

   // ----------------------------------------------------------------
   // Storage and link-side state
   // ----------------------------------------------------------------
   logic [WORD_W-1:0] mem [MEM_WORDS];          // Two words per burst address
   logic              strap_done;               // Strap has been captured
   logic              rd_stage_a;               // Read started at the last rise
   logic              rd_stage_b;               // Read started one cycle earlier
   logic [ADDR_W-1:0] rd_addr_a;
   logic [ADDR_W-1:0] rd_addr_b;
   logic              wr_pend;                  // First write word held
   logic [WORD_W-1:0] wr_word0;
   logic [LANES-1:0]  wr_lanes0;
   logic              wr_addr_hit;              // Fall read hits the committing write
   logic [ADDR_W:0]   fall_idx;
   logic [ADDR_W:0]   rise_idx;
   logic [WORD_W-1:0] next_fall_word;

   // ----------------------------------------------------------------
   // Single clock strap
   // ----------------------------------------------------------------

   // Caught once after reset; later changes on the pins are ignored
   always_ff @(posedge input_timing_pos) begin
      if (link_rst) begin
         strap_done        <= 1'b0;
         single_clock_mode <= 1'b0;
      end else if (!strap_done) begin
         strap_done        <= 1'b1;
         single_clock_mode <= &link_strap;
      end
   end

   // ----------------------------------------------------------------
   // Read port: address capture at the rising input edge
   // ----------------------------------------------------------------

   // Select is looked at here only, never on the falling edge
   always_ff @(posedge input_timing_pos) begin
      if (link_rst) begin
         rd_stage_a <= 1'b0;
         rd_stage_b <= 1'b0;
         rd_addr_a  <= '0;
         rd_addr_b  <= '0;
      end else begin
         rd_stage_a <= !read_port_sel_n;
         rd_stage_b <= rd_stage_a;
         if (!read_port_sel_n) begin
            rd_addr_a <= address;
         end
         rd_addr_b  <= rd_addr_a;
      end
   end

   // ----------------------------------------------------------------
   // Write port: first word at the rising input edge
   // ----------------------------------------------------------------

   // A deselect only stops new writes; one already held still commits
   always_ff @(posedge input_timing_pos) begin
      if (link_rst) begin
         wr_pend   <= 1'b0;
         wr_word0  <= READ_DATA_RST;
         wr_lanes0 <= LANES_OFF;
      end else begin
         wr_pend <= !write_port_sel_n;
         if (!write_port_sel_n) begin
            wr_word0  <= write_data;
            wr_lanes0 <= byte_lane_write_n;
         end
      end
   end

   // ----------------------------------------------------------------
   // Write commit at the falling input edge
   // ----------------------------------------------------------------

   // Address and second word are taken here, then both words land together
   always_ff @(negedge input_timing_pos) begin
      if (wr_pend) begin
         mem[{address, 1'b0}] <= lane_merge(mem[{address, 1'b0}], wr_word0, wr_lanes0);
         mem[{address, 1'b1}] <= lane_merge(mem[{address, 1'b1}], write_data,
                                            byte_lane_write_n);
      end
   end

   // ----------------------------------------------------------------
   // Word selection for the two output halves
   // ----------------------------------------------------------------

   // Loop on: fall carries word 0 and the next rise word 1; loop off swaps
   always_comb begin
      fall_idx = link_bypass_n ? {rd_addr_b, 1'b0} : {rd_addr_b, 1'b1};
      rise_idx = link_bypass_n ? {rd_addr_b, 1'b1} : {rd_addr_a, 1'b0};
   end

   // A write committing on the same falling edge must be forwarded
   always_comb begin
      wr_addr_hit    = wr_pend && (fall_idx[ADDR_W:1] == address);
      next_fall_word = mem[fall_idx];
      if (wr_addr_hit) begin
         if (fall_idx[0]) begin
            next_fall_word = lane_merge(next_fall_word, write_data, byte_lane_write_n);
         end else begin
            next_fall_word = lane_merge(next_fall_word, wr_word0, wr_lanes0);
         end
      end
   end

   // ----------------------------------------------------------------
   // Read output registers
   // ----------------------------------------------------------------

   // Rise half; every earlier write has already committed by now
   always_ff @(posedge input_timing_pos) begin
      if (link_rst) begin
         read_oe_rise <= 1'b0;
         read_q_rise  <= READ_DATA_RST;
      end else begin
         read_oe_rise <= link_bypass_n ? rd_stage_b : rd_stage_a;
         if (link_bypass_n ? rd_stage_b : rd_stage_a) begin
            read_q_rise <= mem[rise_idx];
         end
      end
   end

   // Fall half; the enable drops at once so a neighbour can take over
   always_ff @(negedge input_timing_pos) begin
      if (link_rst) begin
         read_oe_fall <= 1'b0;
         read_q_fall  <= READ_DATA_RST;
      end else begin
         read_oe_fall <= rd_stage_b;
         if (rd_stage_b) begin
            read_q_fall <= next_fall_word;
         end
      end
   end

   // ----------------------------------------------------------------
   // Returned strobes
   // ----------------------------------------------------------------

   // Output registers run on the input pair, so both modes show zero skew
   always_ff @(posedge input_timing_pos) begin
      if (link_rst) begin
         strobe_pos_rise <= 1'b0;
         strobe_neg_rise <= 1'b0;
      end else begin
         strobe_pos_rise <= 1'b1;
         strobe_neg_rise <= 1'b0;
      end
   end

   // Fall halves complete each strobe period
   always_ff @(negedge input_timing_pos) begin
      if (link_rst) begin
         strobe_pos_fall <= 1'b0;
         strobe_neg_fall <= 1'b0;
      end else begin
         strobe_pos_fall <= 1'b0;
         strobe_neg_fall <= 1'b1;
      end
   end

   // No link-side process acts without a link edge, so a stopped clock freezes them all

   // ----------------------------------------------------------------
   // Loop lock tracking, system domain
   // ----------------------------------------------------------------
   dbsp_pll_state_type          pll_state;
   logic [LOCK_CNT_W-1:0]       lock_cnt;

   // Lock is timed on clk; a brief clock stop is too short to see here
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pll_state <= PLL_OFF;
         lock_cnt  <= '0;
      end else begin
         case (pll_state)
            PLL_OFF: begin
               lock_cnt <= '0;
               if (sys_bypass_n) begin
                  pll_state <= PLL_ACQUIRE;
               end
            end
            PLL_ACQUIRE: begin
               if (!sys_bypass_n) begin
                  pll_state <= PLL_OFF;
               end else if (lock_cnt == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
                  pll_state <= PLL_LOCKED;
               end else begin
                  lock_cnt <= lock_cnt + 1'b1;
               end
            end
            PLL_LOCKED: begin
               if (!sys_bypass_n) begin
                  pll_state <= PLL_OFF;
               end
            end
            default: begin
               pll_state <= PLL_OFF;
            end
         endcase
      end
   end

   // Status flop follows the state one cycle later
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pll_locked <= 1'b0;
      end else begin
         pll_locked <= (pll_state == PLL_LOCKED);
      end
   end

   // ----------------------------------------------------------------
   // Impedance recalibration
   // ----------------------------------------------------------------
   logic [RECAL_CNT_W-1:0] recal_cnt;

   // Free-running from reset; the counter wraps on its own width
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         recal_cnt        <= '0;
         impedance_update <= 1'b0;
      end else begin
         recal_cnt        <= recal_cnt + 1'b1;
         impedance_update <= (recal_cnt == RECAL_CNT_W'(RECAL_CYCLES - 1));
      end
   end

endmodule

// File: sim/dbsp_top_sva.sv
// Checker of the burst SRAM port timing
`timescale 1ns/10ps
module dbsp_top_sva (
   input wire logic clk,                // System clock
   input wire logic sys_rst,            // Reset
   input wire logic input_timing_pos,   // Link clock
   input wire logic output_timing_pos,  // Strap pin
   input wire logic output_timing_neg,  // Strap pin
   input wire logic pll_bypass_n,       // Loop off when low
   input wire logic read_port_sel_n,    // Read select
   input wire logic read_oe_rise,       // Rise half enable
   input wire logic read_oe_fall,       // Fall half enable
   input wire logic strobe_pos_rise,    // Strobe half
   input wire logic strobe_pos_fall,    // Strobe half
   input wire logic strobe_neg_rise,    // Strobe half
   input wire logic strobe_neg_fall,    // Strobe half
   input wire logic single_clock_mode,  // Captured strap
   input wire logic pll_locked,         // Lock status
   input wire logic impedance_update    // Recalibration pulse
);
   import dbsp_pkg::*;
   // ----------------------------------------------------------------
   // Helper counters
   // ----------------------------------------------------------------
   logic [1:0]  settle;  // Cycles since release
   logic [10:0] gap;     // Cycles since last pulse
   logic        seen;    // First pulse seen
   logic [7:0]  hi_cnt;  // Cycles with loop on
   // Counters saturate or clear
   always_ff @(posedge clk) begin
      if (sys_rst) settle <= 2'h0;
      else if (settle != 2'h3) settle <= settle + 2'h1;
   end
   always_ff @(posedge clk) begin
      if (sys_rst || impedance_update) gap <= 11'h000;
      else gap <= gap + 11'h001;
   end
   always_ff @(posedge clk) begin
      if (sys_rst) seen <= 1'b0;
      else if (impedance_update) seen <= 1'b1;
   end
   always_ff @(posedge clk) begin
      if (sys_rst || !pll_bypass_n) hi_cnt <= 8'h00;
      else if (hi_cnt != 8'hFF) hi_cnt <= hi_cnt + 8'h01;
   end
   // ----------------------------------------------------------------
   // Sequences and assertions
   // ----------------------------------------------------------------
   sequence seq_words_on;
      ##2 read_oe_fall ##1 read_oe_rise;
   endsequence
   sequence seq_quiet;
      read_port_sel_n [*4];
   endsequence
   read_loop_on_a: assert property (@(posedge input_timing_pos) disable iff (sys_rst)
      !read_port_sel_n && pll_bypass_n && $past(pll_bypass_n, 8) |-> seq_words_on) else $error("loop-on read late");
   read_legacy_a: assert property (@(posedge input_timing_pos) disable iff (sys_rst)
      !read_port_sel_n && !pll_bypass_n && !$past(pll_bypass_n, 8) |-> ##2 read_oe_rise && read_oe_fall)
      else $error("legacy read late");
   idle_float_a: assert property (@(posedge input_timing_pos) disable iff (sys_rst)
      seq_quiet |-> !read_oe_rise && !read_oe_fall) else $error("outputs driven while idle");
   reset_quiet_a: assert property (@(posedge clk)
      sys_rst [*4] |-> !read_oe_rise && !read_oe_fall && !pll_locked) else $error("active in reset");
   strobe_run_a: assert property (@(posedge clk) disable iff (sys_rst)
      settle == 2'h3 |-> strobe_pos_rise && !strobe_pos_fall && !strobe_neg_rise && strobe_neg_fall)
      else $error("strobe pattern wrong");
   strap_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
      settle == 2'h3 |-> single_clock_mode == (output_timing_pos && output_timing_neg)) else $error("strap wrong");
   recal_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
      impedance_update && seen |-> gap == 11'(RECAL_CYCLES - 1)) else $error("recal period wrong");
   recal_due_a: assert property (@(posedge clk) disable iff (sys_rst)
      seen |-> (gap <= 11'(RECAL_CYCLES - 1)) and (impedance_update |=> !impedance_update)) else $error("pulse missed");
   lock_early_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(pll_locked) |-> hi_cnt >= 8'(LOCK_CYCLES)) else $error("lock too early");
   lock_late_a: assert property (@(posedge clk) disable iff (sys_rst)
      hi_cnt == 8'(LOCK_CYCLES + 20) |-> pll_locked) else $error("lock too late");
   unlock_a: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(pll_bypass_n) |-> ##[1:4] !pll_locked) else $error("lock kept");
endmodule

bind dbsp_top dbsp_top_sva i_sva (.clk(clk), .sys_rst(sys_rst), .input_timing_pos(input_timing_pos),
   .output_timing_pos(output_timing_pos), .output_timing_neg(output_timing_neg), .pll_bypass_n(pll_bypass_n),
   .read_port_sel_n(read_port_sel_n), .read_oe_rise(read_oe_rise), .read_oe_fall(read_oe_fall),
   .strobe_pos_rise(strobe_pos_rise), .strobe_pos_fall(strobe_pos_fall), .strobe_neg_rise(strobe_neg_rise),
   .strobe_neg_fall(strobe_neg_fall), .single_clock_mode(single_clock_mode), .pll_locked(pll_locked),
   .impedance_update(impedance_update));

// File: sim/dbsp_ctrl_model.sv
// Memory controller model: link clock and both ports
`timescale 1ns/10ps
module dbsp_ctrl_model (
   output logic                        input_timing_pos,  // Link clock, 6 ns
   output logic                        read_port_sel_n,   // Read select
   output logic                        write_port_sel_n,  // Write select
   output logic [dbsp_pkg::ADDR_W-1:0] address,           // Shared address
   output logic [dbsp_pkg::WORD_W-1:0] write_data,        // Write word
   output logic [dbsp_pkg::LANES-1:0]  byte_lane_write_n  // Lane selects
);
   import dbsp_pkg::*;
   // Clock never stops, so no loop reset
   initial begin
      input_timing_pos  = 1'b0;
      read_port_sel_n   = 1'b1;
      write_port_sel_n  = 1'b1;
      address           = 8'h00;
      write_data        = 18'h00000;
      byte_lane_write_n = 2'h3;
      #1.3;
      forever #3 input_timing_pos = ~input_timing_pos;
   end
   // One slot: rise half, then fall half
   task automatic access(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr,
                         input logic [ADDR_W-1:0] wa, input logic [WORD_W-1:0] w0, w1,
                         input logic [LANES-1:0] l0, l1);
      @(posedge input_timing_pos);
      #1;
      read_port_sel_n   = !rd;
      write_port_sel_n  = !wr;
      address           = ra;
      write_data        = w0;
      byte_lane_write_n = l0;
      @(posedge input_timing_pos);
      #1;
      read_port_sel_n   = 1'b1;
      write_port_sel_n  = 1'b1;
      address           = wa;
      write_data        = w1;
      byte_lane_write_n = l1;
      @(negedge input_timing_pos);
      #1;
      // Released lines show the inverse
      address           = ~wa;
      write_data        = ~w1;
      byte_lane_write_n = ~l1;
   endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench of the burst SRAM ports
`timescale 1ns/10ps
module tb_top;
   import dbsp_pkg::*;
   logic              clk, sys_rst, output_timing_pos, output_timing_neg, pll_bypass_n;
   wire               input_timing_pos, read_port_sel_n, write_port_sel_n;
   wire [ADDR_W-1:0]  address;
   wire [WORD_W-1:0]  write_data, read_q_rise, read_q_fall;
   wire [LANES-1:0]   byte_lane_write_n;
   wire               read_oe_rise, read_oe_fall, strobe_pos_rise, strobe_pos_fall, strobe_neg_rise;
   wire               strobe_neg_fall, single_clock_mode, pll_locked, impedance_update;
   int                bad_count, checks_done, cyc;

   dbsp_ctrl_model i_ctrl (.input_timing_pos(input_timing_pos), .read_port_sel_n(read_port_sel_n),
      .write_port_sel_n(write_port_sel_n), .address(address), .write_data(write_data),
      .byte_lane_write_n(byte_lane_write_n));
   dbsp_top i_dut (.clk(clk), .sys_rst(sys_rst), .input_timing_pos(input_timing_pos),
      .output_timing_pos(output_timing_pos), .output_timing_neg(output_timing_neg), .pll_bypass_n(pll_bypass_n),
      .read_port_sel_n(read_port_sel_n), .write_port_sel_n(write_port_sel_n), .address(address),
      .write_data(write_data), .byte_lane_write_n(byte_lane_write_n), .read_q_rise(read_q_rise),
      .read_oe_rise(read_oe_rise), .read_q_fall(read_q_fall), .read_oe_fall(read_oe_fall),
      .strobe_pos_rise(strobe_pos_rise), .strobe_pos_fall(strobe_pos_fall), .strobe_neg_rise(strobe_neg_rise),
      .strobe_neg_fall(strobe_neg_fall), .single_clock_mode(single_clock_mode), .pll_locked(pll_locked),
      .impedance_update(impedance_update));

   // ----------------------------------------------------------------
   // Clock, hang guard and shared tasks
   // ----------------------------------------------------------------
   always #50 clk = ~clk;
   // Run is near 2100 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [WORD_W-1:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // High lane select keeps old byte
   function automatic logic [WORD_W-1:0] mrg(input logic [WORD_W-1:0] o, n,
                                             input logic [LANES-1:0] l);
      mrg = {l[1] ? o[17:9] : n[17:9], l[0] ? o[8:0] : n[8:0]};
   endfunction
   // Judges a read and the float after
   task automatic rd_check(input logic legacy, input logic [WORD_W-1:0] e0, e1);
      @(posedge input_timing_pos);
      #1;
      if (legacy) begin
         chk("oe rise", read_oe_rise, 1'b1);
         chk("q rise", read_q_rise, e0);
      end
      @(negedge input_timing_pos);
      #1;
      chk("oe fall", read_oe_fall, 1'b1);
      chk("q fall", read_q_fall, legacy ? e1 : e0);
      if (!legacy) begin
         @(posedge input_timing_pos);
         #1;
         chk("oe rise", read_oe_rise, 1'b1);
         chk("q rise", read_q_rise, e1);
      end
      repeat (2) @(posedge input_timing_pos);
      #1;
      chk("oe float", {read_oe_rise, read_oe_fall}, 2'h0);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic do_reset(input logic strap);
      @(posedge clk);
      #1;
      sys_rst = 1'b1;
      output_timing_pos = strap;
      output_timing_neg = strap;
      repeat (20) @(posedge clk);
      #1;
      chk("reset outputs", {read_oe_rise, read_oe_fall, pll_locked, impedance_update}, 4'h0);
      sys_rst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("strobes", {strobe_pos_rise, strobe_pos_fall, strobe_neg_rise, strobe_neg_fall}, 4'h9);
      chk("clock mode", single_clock_mode, strap);
      $display("test reset done");
   endtask
   task automatic t_lanes();
      logic [WORD_W-1:0] e0, e1;
      {e0, e1} = '0;
      i_ctrl.access(1'b0, 8'h00, 1'b1, 8'h09, e0, e1, 2'h0, 2'h0);
      // Each lane code, mirrored on word 1
      for (int c = 0; c < 4; c++) begin
         i_ctrl.access(1'b0, 8'h00, 1'b1, 8'h09, 18'h3FFFF - 18'(c), 18'h2AAAA + 18'(c), 2'(c), 2'(3 - c));
         e0 = mrg(e0, 18'h3FFFF - 18'(c), 2'(c));
         e1 = mrg(e1, 18'h2AAAA + 18'(c), 2'(3 - c));
         i_ctrl.access(1'b1, 8'h09, 1'b0, 8'h00, 18'h00000, 18'h00000, 2'h0, 2'h0);
         rd_check(1'b0, e0, e1);
      end
      $display("test lanes done");
   endtask
   task automatic t_ports();
      i_ctrl.access(1'b0, 8'h00, 1'b1, 8'h20, 18'h00111, 18'h00222, 2'h0, 2'h0);
      i_ctrl.access(1'b1, 8'h20, 1'b1, 8'h21, 18'h00333, 18'h00444, 2'h0, 2'h0);
      rd_check(1'b0, 18'h00111, 18'h00222);
      i_ctrl.access(1'b1, 8'h21, 1'b1, 8'h21, 18'h00555, 18'h00666, 2'h0, 2'h0);
      rd_check(1'b0, 18'h00555, 18'h00666);
      // Deselected write must not land
      i_ctrl.access(1'b0, 8'h00, 1'b0, 8'h20, 18'h3FFFF, 18'h3FFFF, 2'h0, 2'h0);
      i_ctrl.access(1'b1, 8'h20, 1'b0, 8'h00, 18'h00000, 18'h00000, 2'h0, 2'h0);
      rd_check(1'b0, 18'h00111, 18'h00222);
      $display("test ports done");
   endtask
   task automatic t_loop();
      repeat (LOCK_CYCLES + 30) @(posedge clk);
      #1;
      chk("locked", pll_locked, 1'b1);
      pll_bypass_n = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      chk("unlocked", pll_locked, 1'b0);
      i_ctrl.access(1'b1, 8'h21, 1'b0, 8'h00, 18'h00000, 18'h00000, 2'h0, 2'h0);
      rd_check(1'b1, 18'h00555, 18'h00666);
      @(posedge clk);
      #1;
      pll_bypass_n = 1'b1;
      $display("test loop done");
   endtask
   task automatic t_recal();
      int n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (impedance_update !== 1'b1 && n < 1100);
      end
      chk("recal gap", 18'(n), 18'(RECAL_CYCLES));
      $display("test recal done");
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      output_timing_pos = 1'b0;
      output_timing_neg = 1'b0;
      pll_bypass_n = 1'b1;
      bad_count = 0;
      checks_done = 0;
      cyc = 0;
      do_reset(1'b0);
      i_ctrl.access(1'b0, 8'h00, 1'b1, 8'h05, 18'h2A5A5, 18'h15A5A, 2'h0, 2'h0);
      i_ctrl.access(1'b1, 8'h05, 1'b0, 8'h00, 18'h00000, 18'h00000, 2'h0, 2'h0);
      rd_check(1'b0, 18'h2A5A5, 18'h15A5A);
      t_lanes();
      t_ports();
      t_loop();
      t_recal();
      do_reset(1'b1);
      finish_test();
   end
endmodule
